// [design/txpei_pkg.sv]
package txpei_pkg;

   localparam int         NUM_CH           = 4;
   localparam int         ADDR_W           = 8;
   localparam int         DATA_W           = 32;
   localparam int         CNT_W            = 10;

   // character counts of one self-test pass
   localparam logic [9:0] PASS_CHARS       = 10'h1ff;
   localparam logic [9:0] WORD_SYNC_CHARS  = 10'h010;

   // register byte offsets
   localparam logic [7:0] CTRL_OFFSET      = 8'h00;
   localparam logic [7:0] STATUS_OFFSET    = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFFSET  = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFFSET  = 8'h0c;
   localparam logic [7:0] PASS_CNT_OFFSET  = 8'h10;
   localparam logic [7:0] FAULT_CNT_OFFSET = 8'h14;

   // control register fields
   localparam int         CTRL_BIST_POS    = 0;
   localparam int         CTRL_COMMON_POS  = 4;
   localparam int         CTRL_CKSEL_POS   = 5;
   localparam int         CTRL_RATE_POS    = 6;

   // status register fields
   localparam int         STAT_ERR_POS     = 0;
   localparam int         STAT_FAULT_POS   = 4;
   localparam int         STAT_REALIGN_POS = 8;

   // interrupt status / mask fields
   localparam int         IRQ_PASS_POS     = 0;
   localparam int         IRQ_FAULT_POS    = 4;

   localparam logic [6:0]  CTRL_RESET      = 7'h00;
   localparam logic [7:0]  IRQ_MASK_RESET  = 8'h00;
   localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } txpei_bus_req_type;

   typedef struct packed {
      logic        bist_en;
      logic        common_clk;
      logic        buf_en;
      logic        underflow;
      logic        overflow;
      logic        word_sync_sent;
      logic        realign_active;
   } txpei_chan_in_type;

   typedef struct packed {
      logic        err;
      logic        fault;
      logic        pass_evt;
      logic        fault_evt;
   } txpei_chan_out_type;

endpackage

// [design/txpei_chan.sv]
module txpei_chan
(
   input  wire logic                         clk_i,
   input  wire logic                         rst_b_i,
   input  wire txpei_pkg::txpei_chan_in_type chan_i,
   output txpei_pkg::txpei_chan_out_type     chan_o
);

   typedef struct packed {
      logic [9:0] cnt;
      logic       err;
      logic       fault;
      logic       pass_evt;
      logic       fault_evt;
   } txpei_chan_state_type;

   txpei_chan_state_type state_ff;
   txpei_chan_state_type nxt_state;

   logic [9:0] last_cnt;
   logic       pass_now;
   logic       fault_set;
   logic       fault_clr;

   always_comb
   begin
      nxt_state = state_ff;
      last_cnt  = chan_i.common_clk ?
                  10'(txpei_pkg::PASS_CHARS + txpei_pkg::WORD_SYNC_CHARS - 10'h001) :
                  10'(txpei_pkg::PASS_CHARS - 10'h001);
      pass_now  = chan_i.bist_en && (state_ff.cnt == last_cnt);
      if (!chan_i.bist_en || pass_now)
      begin
         nxt_state.cnt = 10'h000;
      end
      else
      begin
         nxt_state.cnt = 10'(state_ff.cnt + 10'h001);
      end
      fault_set = chan_i.buf_en && (chan_i.underflow || chan_i.overflow);
      fault_clr = chan_i.word_sync_sent || chan_i.realign_active;
      // a fault in the clearing cycle is kept
      nxt_state.fault     = fault_set || (state_ff.fault && !fault_clr);
      nxt_state.fault_evt = fault_set && !state_ff.fault;
      nxt_state.pass_evt  = pass_now;
      nxt_state.err       = pass_now || nxt_state.fault;
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign chan_o.err       = state_ff.err;
   assign chan_o.fault     = state_ff.fault;
   assign chan_o.pass_evt  = state_ff.pass_evt;
   assign chan_o.fault_evt = state_ff.fault_evt;

endmodule

// [design/txpei_top.sv]
// Behaviour
// - one active-high error output per channel
// - self-test pulses output every 511 characters
// - common clock adds 16-character word sync
// - buffers enabled: select high, or half-rate
// - buffer fault latched until sync or realign
// - characters may slip during re-centring
module txpei_top
(
   input  wire logic        CORE_CLK_I,
   input  wire logic        RST_B_I,
   input  wire logic [7:0]  BUS_ADDR_I,
   input  wire logic [31:0] BUS_WDATA_I,
   input  wire logic        BUS_WR_I,
   input  wire logic        BUS_RD_I,
   output logic      [31:0] BUS_RDATA_O,
   input  wire logic [3:0]  BUF_UNDERFLOW_I,
   input  wire logic [3:0]  BUF_OVERFLOW_I,
   input  wire logic [3:0]  WORD_SYNC_SENT_I,
   input  wire logic        TX_REALIGN_RESET_B_I,
   output logic             TX_PATH_ERROR_A_O,
   output logic             TX_PATH_ERROR_B_O,
   output logic             TX_PATH_ERROR_C_O,
   output logic             TX_PATH_ERROR_D_O,
   output logic             REALIGN_ACTIVE_O,
   output logic             IRQ_O
);

   typedef struct packed {
      logic [3:0]  bist_en;
      logic        common_clk;
      logic        tx_clock_select;
      logic        tx_half_rate_select;
      logic [7:0]  irq_stat;
      logic [7:0]  irq_mask;
      logic [31:0] rdata;
      logic        realign_meta;
      logic        realign_sync;
      logic [31:0] pass_cnt;
      logic [31:0] fault_cnt;
   } txpei_state_type;

   txpei_state_type                           state_ff;
   txpei_state_type                           nxt_state;
   txpei_pkg::txpei_bus_req_type              bus_req;
   txpei_pkg::txpei_chan_in_type  [3:0]       chan_in;
   txpei_pkg::txpei_chan_out_type [3:0]       chan_out;
   logic                          [3:0]       err_vec;
   logic                          [3:0]       fault_vec;
   logic                          [3:0]       pass_vec;
   logic                          [3:0]       fault_evt_vec;
   logic                                      buf_en;
   logic                                      realign_active;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
      hit = (addr == offset);
   endfunction

   function automatic logic [31:0] bump_bytes(input logic [31:0] cnts,
                                              input logic [3:0]  evts);
      logic [31:0] res;
      res = cnts;
      for (int i = 0; i < txpei_pkg::NUM_CH; i++)
      begin
         // saturate rather than wrap so a storm stays visible
         if (evts[i] && (cnts[8*i +: 8] != 8'hff))
         begin
            res[8*i +: 8] = 8'(cnts[8*i +: 8] + 8'h01);
         end
      end
      bump_bytes = res;
   endfunction

   assign bus_req.addr  = BUS_ADDR_I;
   assign bus_req.wdata = BUS_WDATA_I;
   assign bus_req.wr    = BUS_WR_I;
   assign bus_req.rd    = BUS_RD_I;

   assign buf_en = state_ff.tx_clock_select || state_ff.tx_half_rate_select;

   assign realign_active = !state_ff.realign_sync;

   genvar ch;
   generate
      for (ch = 0; ch < txpei_pkg::NUM_CH; ch++)
      begin : g_chan
         assign chan_in[ch].bist_en        = state_ff.bist_en[ch];
         assign chan_in[ch].common_clk     = state_ff.common_clk;
         assign chan_in[ch].buf_en         = buf_en;
         assign chan_in[ch].underflow      = BUF_UNDERFLOW_I[ch];
         assign chan_in[ch].overflow       = BUF_OVERFLOW_I[ch];
         assign chan_in[ch].word_sync_sent = WORD_SYNC_SENT_I[ch];
         assign chan_in[ch].realign_active = realign_active;

         txpei_chan u_chan
         (
            .clk_i   (CORE_CLK_I),
            .rst_b_i (RST_B_I),
            .chan_i  (chan_in[ch]),
            .chan_o  (chan_out[ch])
         );

         assign err_vec[ch]       = chan_out[ch].err;
         assign fault_vec[ch]     = chan_out[ch].fault;
         assign pass_vec[ch]      = chan_out[ch].pass_evt;
         assign fault_evt_vec[ch] = chan_out[ch].fault_evt;
      end
   endgenerate

   always_comb
   begin
      nxt_state = state_ff;

      // realign pin is asynchronous to the core clock
      nxt_state.realign_meta = TX_REALIGN_RESET_B_I;
      nxt_state.realign_sync = state_ff.realign_meta;

      if (bus_req.wr && hit(bus_req.addr, txpei_pkg::CTRL_OFFSET))
      begin
         nxt_state.bist_en             = bus_req.wdata[txpei_pkg::CTRL_BIST_POS +: 4];
         nxt_state.common_clk          = bus_req.wdata[txpei_pkg::CTRL_COMMON_POS];
         nxt_state.tx_clock_select     = bus_req.wdata[txpei_pkg::CTRL_CKSEL_POS];
         nxt_state.tx_half_rate_select = bus_req.wdata[txpei_pkg::CTRL_RATE_POS];
      end

      if (bus_req.wr && hit(bus_req.addr, txpei_pkg::IRQ_MASK_OFFSET))
      begin
         nxt_state.irq_mask = bus_req.wdata[7:0];
      end

      // write-one-to-clear, new events win over the clear
      if (bus_req.wr && hit(bus_req.addr, txpei_pkg::IRQ_STAT_OFFSET))
      begin
         nxt_state.irq_stat = state_ff.irq_stat & ~bus_req.wdata[7:0];
      end
      nxt_state.irq_stat[txpei_pkg::IRQ_PASS_POS +: 4]  =
         nxt_state.irq_stat[txpei_pkg::IRQ_PASS_POS +: 4] | pass_vec;
      nxt_state.irq_stat[txpei_pkg::IRQ_FAULT_POS +: 4] =
         nxt_state.irq_stat[txpei_pkg::IRQ_FAULT_POS +: 4] | fault_evt_vec;

      // each counter cleared by a write to its own offset; events in that cycle still count
      if (bus_req.wr && hit(bus_req.addr, txpei_pkg::PASS_CNT_OFFSET))
      begin
         nxt_state.pass_cnt = 32'h0000_0000;
      end
      nxt_state.pass_cnt = bump_bytes(nxt_state.pass_cnt, pass_vec);
      if (bus_req.wr && hit(bus_req.addr, txpei_pkg::FAULT_CNT_OFFSET))
      begin
         nxt_state.fault_cnt = 32'h0000_0000;
      end
      nxt_state.fault_cnt = bump_bytes(nxt_state.fault_cnt, fault_evt_vec);

      // read data valid only in the cycle after the strobe
      nxt_state.rdata = 32'h0000_0000;
      if (bus_req.rd)
      begin
         case (bus_req.addr)
            txpei_pkg::CTRL_OFFSET:
            begin
               nxt_state.rdata[txpei_pkg::CTRL_BIST_POS +: 4]  = state_ff.bist_en;
               nxt_state.rdata[txpei_pkg::CTRL_COMMON_POS]     = state_ff.common_clk;
               nxt_state.rdata[txpei_pkg::CTRL_CKSEL_POS]      = state_ff.tx_clock_select;
               nxt_state.rdata[txpei_pkg::CTRL_RATE_POS]       = state_ff.tx_half_rate_select;
            end
            txpei_pkg::STATUS_OFFSET:
            begin
               nxt_state.rdata[txpei_pkg::STAT_ERR_POS +: 4]   = err_vec;
               nxt_state.rdata[txpei_pkg::STAT_FAULT_POS +: 4] = fault_vec;
               nxt_state.rdata[txpei_pkg::STAT_REALIGN_POS]    = realign_active;
            end
            txpei_pkg::IRQ_STAT_OFFSET:
            begin
               nxt_state.rdata[7:0] = state_ff.irq_stat;
            end
            txpei_pkg::IRQ_MASK_OFFSET:
            begin
               nxt_state.rdata[7:0] = state_ff.irq_mask;
            end
            txpei_pkg::PASS_CNT_OFFSET:
            begin
               nxt_state.rdata = state_ff.pass_cnt;
            end
            txpei_pkg::FAULT_CNT_OFFSET:
            begin
               nxt_state.rdata = state_ff.fault_cnt;
            end
            default:
            begin
               nxt_state.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         state_ff.bist_en             <= txpei_pkg::CTRL_RESET[3:0];
         state_ff.common_clk          <= txpei_pkg::CTRL_RESET[4];
         state_ff.tx_clock_select     <= txpei_pkg::CTRL_RESET[5];
         state_ff.tx_half_rate_select <= txpei_pkg::CTRL_RESET[6];
         state_ff.irq_stat            <= 8'h00;
         state_ff.irq_mask            <= txpei_pkg::IRQ_MASK_RESET;
         state_ff.rdata               <= txpei_pkg::RDATA_RESET;
         // idle pin level is high, so no false realign after reset
         state_ff.realign_meta        <= 1'b1;
         state_ff.realign_sync        <= 1'b1;
         state_ff.pass_cnt            <= 32'h0000_0000;
         state_ff.fault_cnt           <= 32'h0000_0000;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign BUS_RDATA_O = state_ff.rdata;

   assign TX_PATH_ERROR_A_O = err_vec[0];
   assign TX_PATH_ERROR_B_O = err_vec[1];
   assign TX_PATH_ERROR_C_O = err_vec[2];
   assign TX_PATH_ERROR_D_O = err_vec[3];

   assign REALIGN_ACTIVE_O = realign_active;

   assign IRQ_O = |(state_ff.irq_stat & state_ff.irq_mask);

endmodule

// [test/txpei_asserts.sv]
module txpei_asserts
(
   input  wire logic        CORE_CLK_I,
   input  wire logic        RST_B_I,
   input  wire logic [7:0]  BUS_ADDR_I,
   input  wire logic [31:0] BUS_WDATA_I,
   input  wire logic        BUS_WR_I,
   input  wire logic        BUS_RD_I,
   input  wire logic [31:0] BUS_RDATA_O,
   input  wire logic [3:0]  BUF_UNDERFLOW_I,
   input  wire logic [3:0]  BUF_OVERFLOW_I,
   input  wire logic [3:0]  WORD_SYNC_SENT_I,
   input  wire logic        TX_PATH_ERROR_A_O,
   input  wire logic        TX_PATH_ERROR_B_O,
   input  wire logic        TX_PATH_ERROR_C_O,
   input  wire logic        TX_PATH_ERROR_D_O,
   input  wire logic        REALIGN_ACTIVE_O,
   input  wire logic        IRQ_O
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_B_I);
   logic [6:0] ctrl_ff;
   logic [7:0] mask_ff;
   logic [9:0] gap_ff;
   logic       armed_ff;
   logic [3:0] errs;
   logic [3:0] flt;
   logic       buf_en;
   logic       keep;
   assign errs = {TX_PATH_ERROR_D_O, TX_PATH_ERROR_C_O, TX_PATH_ERROR_B_O, TX_PATH_ERROR_A_O};
   assign flt = BUF_UNDERFLOW_I | BUF_OVERFLOW_I;
   assign buf_en = ctrl_ff[5] | ctrl_ff[6];
   // any write or realign breaks the pass rhythm, so rearm
   assign keep = ctrl_ff[0] && !buf_en && !BUS_WR_I && !REALIGN_ACTIVE_O;
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         ctrl_ff <= 7'h00;
         mask_ff <= 8'h00;
         gap_ff <= 10'h000;
         armed_ff <= 1'b0;
      end
      else
      begin
         if (BUS_WR_I && BUS_ADDR_I == txpei_pkg::CTRL_OFFSET)
            ctrl_ff <= BUS_WDATA_I[6:0];
         if (BUS_WR_I && BUS_ADDR_I == txpei_pkg::IRQ_MASK_OFFSET)
            mask_ff <= BUS_WDATA_I[7:0];
         gap_ff <= TX_PATH_ERROR_A_O ? 10'h000 : gap_ff + 10'h001;
         armed_ff <= keep && (armed_ff || TX_PATH_ERROR_A_O);
      end
   end
   property p_fset; buf_en && flt != 4'h0 |=> (errs & $past(flt)) == $past(flt); endproperty
   a_fset: assert property (p_fset) else $error("fault not flagged");
   property p_ign; !buf_en && ctrl_ff[3:0] == 4'h0 && errs == 4'h0 |=> errs == 4'h0; endproperty
   a_ign: assert property (p_ign) else $error("fault taken while disabled");
   // latch holds
   // a pass pulse may outlive its enable by one cycle
   property p_hold;
      !REALIGN_ACTIVE_O
      |=> (errs | ~($past(errs & ~WORD_SYNC_SENT_I & ~ctrl_ff[3:0]) & ~$past(ctrl_ff[3:0], 2)))
          == 4'hf;
   endproperty
   a_hold: assert property (p_hold) else $error("fault dropped early");
   property p_sclr;
      (WORD_SYNC_SENT_I & ~flt & ~ctrl_ff[3:0]) != 4'h0
      |=> (errs & $past(WORD_SYNC_SENT_I & ~flt & ~ctrl_ff[3:0])) == 4'h0;
   endproperty
   a_sclr: assert property (p_sclr) else $error("sync did not clear");
   property p_rclr; REALIGN_ACTIVE_O && flt == 4'h0 && ctrl_ff[3:0] == 4'h0 |=> errs == 4'h0;
   endproperty
   a_rclr: assert property (p_rclr) else $error("realign did not clear");
   property p_per;
      // rise only, a latched fault holds the pin high
      $rose(TX_PATH_ERROR_A_O) && armed_ff |-> gap_ff == (ctrl_ff[4] ? 10'h20e : 10'h1fe);
   endproperty
   a_per: assert property (p_per) else $error("pass pulse off period");
   // read data only after a read
   property p_rdat; !BUS_RD_I |=> BUS_RDATA_O == 32'h0000_0000; endproperty
   a_rdat: assert property (p_rdat) else $error("stray read data");
   // masked interrupt quiet
   property p_irq; mask_ff == 8'h00 |-> !IRQ_O; endproperty
   a_irq: assert property (p_irq) else $error("masked interrupt raised");
endmodule

// [test/txpei_realign_drv.sv]
module txpei_realign_drv
(
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic go_i,
   output logic      realign_b_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] low_cnt_ff;
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         low_cnt_ff <= 2'h0;
      else if (go_i)
         low_cnt_ff <= 2'h2;
      else if (low_cnt_ff != 2'h0)
         low_cnt_ff <= low_cnt_ff - 2'h1;
   end
   // pin has a pull-up, so idle is high
   assign realign_b_o = (low_cnt_ff == 2'h0);
endmodule

// [test/tb_top.sv]
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
   $display("ERROR %s expected %0h seen %0h", n, e, a); end end
   logic        CORE_CLK_I, RST_B_I, BUS_WR_I, BUS_RD_I, go;
   logic [7:0]  BUS_ADDR_I;
   logic [31:0] BUS_WDATA_I, BUS_RDATA_O;
   logic [3:0]  BUF_UNDERFLOW_I, BUF_OVERFLOW_I, WORD_SYNC_SENT_I, err;
   logic        TX_PATH_ERROR_A_O, TX_PATH_ERROR_B_O, TX_PATH_ERROR_C_O, TX_PATH_ERROR_D_O;
   logic        REALIGN_ACTIVE_O, IRQ_O;
   wire logic   TX_REALIGN_RESET_B_I;
   int          num_errors, num_checks, cyc;
   assign err = {TX_PATH_ERROR_D_O, TX_PATH_ERROR_C_O, TX_PATH_ERROR_B_O, TX_PATH_ERROR_A_O};
   txpei_top i_txpei_top
   (
      .CORE_CLK_I           (CORE_CLK_I),
      .RST_B_I              (RST_B_I),
      .BUS_ADDR_I           (BUS_ADDR_I),
      .BUS_WDATA_I          (BUS_WDATA_I),
      .BUS_WR_I             (BUS_WR_I),
      .BUS_RD_I             (BUS_RD_I),
      .BUS_RDATA_O          (BUS_RDATA_O),
      .BUF_UNDERFLOW_I      (BUF_UNDERFLOW_I),
      .BUF_OVERFLOW_I       (BUF_OVERFLOW_I),
      .WORD_SYNC_SENT_I     (WORD_SYNC_SENT_I),
      .TX_REALIGN_RESET_B_I (TX_REALIGN_RESET_B_I),
      .TX_PATH_ERROR_A_O    (TX_PATH_ERROR_A_O),
      .TX_PATH_ERROR_B_O    (TX_PATH_ERROR_B_O),
      .TX_PATH_ERROR_C_O    (TX_PATH_ERROR_C_O),
      .TX_PATH_ERROR_D_O    (TX_PATH_ERROR_D_O),
      .REALIGN_ACTIVE_O     (REALIGN_ACTIVE_O),
      .IRQ_O                (IRQ_O)
   );
   txpei_realign_drv i_txpei_realign_drv (.clk_i(CORE_CLK_I), .rst_b_i(RST_B_I), .go_i(go),
                                          .realign_b_o(TX_REALIGN_RESET_B_I));
   initial
   begin
      CORE_CLK_I = 1'b0;
      forever #50 CORE_CLK_I = ~CORE_CLK_I;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge CORE_CLK_I);
      BUS_ADDR_I <= a;
      BUS_WDATA_I <= d;
      BUS_WR_I <= 1'b1;
      @(posedge CORE_CLK_I);
      BUS_WR_I <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge CORE_CLK_I);
      BUS_ADDR_I <= a;
      BUS_RD_I <= 1'b1;
      @(posedge CORE_CLK_I);
      BUS_RD_I <= 1'b0;
      #1 `CHK("rdata", e, BUS_RDATA_O)
   endtask
   task automatic pulse_at(input int n, input logic [3:0] m);
      repeat (n - 1) @(posedge CORE_CLK_I);
      #1 `CHK("quiet", 4'h0, err)
      @(posedge CORE_CLK_I);
      #1 `CHK("pulse", m, err)
   endtask
   task automatic t_reset;
      #1 `CHK("err", 4'h0, err)
      rd_chk(txpei_pkg::CTRL_OFFSET, 32'h0);
      rd_chk(txpei_pkg::IRQ_MASK_OFFSET, 32'h0);
      rd_chk(8'h20, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_bist;
      wr_reg(txpei_pkg::CTRL_OFFSET, 32'h1);
      // first pulse comes 511 edges after the write edge
      pulse_at(511, 4'h1);
      pulse_at(511, 4'h1);
      wr_reg(txpei_pkg::CTRL_OFFSET, 32'h0);
      wr_reg(txpei_pkg::CTRL_OFFSET, 32'h11);
      pulse_at(527, 4'h1);
      pulse_at(527, 4'h1);
      wr_reg(txpei_pkg::CTRL_OFFSET, 32'h0);
      wr_reg(txpei_pkg::CTRL_OFFSET, 32'hf);
      pulse_at(511, 4'hf);
      wr_reg(txpei_pkg::CTRL_OFFSET, 32'h0);
      rd_chk(txpei_pkg::PASS_CNT_OFFSET, 32'h01010105);
      rd_chk(txpei_pkg::IRQ_STAT_OFFSET, 32'hf);
      `CHK("irq", 1'b0, IRQ_O)
      wr_reg(txpei_pkg::IRQ_MASK_OFFSET, 32'h1);
      #1 `CHK("irq", 1'b1, IRQ_O)
      wr_reg(txpei_pkg::IRQ_STAT_OFFSET, 32'hf);
      #1 `CHK("irq", 1'b0, IRQ_O)
      $display("test self-test done");
   endtask
   task automatic t_fault;
      wr_reg(txpei_pkg::CTRL_OFFSET, 32'h20);
      @(posedge CORE_CLK_I) BUF_UNDERFLOW_I <= 4'h2;
      @(posedge CORE_CLK_I) BUF_UNDERFLOW_I <= 4'h0;
      #1 `CHK("set", 4'h2, err)
      repeat (3) @(posedge CORE_CLK_I);
      #1 `CHK("hold", 4'h2, err)
      rd_chk(txpei_pkg::STATUS_OFFSET, 32'h22);
      @(posedge CORE_CLK_I) WORD_SYNC_SENT_I <= 4'h2;
      @(posedge CORE_CLK_I) WORD_SYNC_SENT_I <= 4'h0;
      #1 `CHK("sync", 4'h0, err)
      rd_chk(txpei_pkg::IRQ_STAT_OFFSET, 32'h20);
      wr_reg(txpei_pkg::CTRL_OFFSET, 32'h40);
      @(posedge CORE_CLK_I) BUF_OVERFLOW_I <= 4'h8;
      @(posedge CORE_CLK_I) BUF_OVERFLOW_I <= 4'h0;
      #1 `CHK("rate", 4'h8, err)
      @(posedge CORE_CLK_I) go <= 1'b1;
      @(posedge CORE_CLK_I) go <= 1'b0;
      for (int i = 0; i < 8 && REALIGN_ACTIVE_O !== 1'b1; i++)
         @(posedge CORE_CLK_I) #1;
      `CHK("realign", 1'b1, REALIGN_ACTIVE_O)
      repeat (3) @(posedge CORE_CLK_I);
      #1 `CHK("cleared", 4'h0, err)
      wr_reg(txpei_pkg::CTRL_OFFSET, 32'h0);
      @(posedge CORE_CLK_I) BUF_UNDERFLOW_I <= 4'hf;
      @(posedge CORE_CLK_I) BUF_UNDERFLOW_I <= 4'h0;
      #1 `CHK("off", 4'h0, err)
      rd_chk(txpei_pkg::FAULT_CNT_OFFSET, 32'h01000100);
      $display("test fault done");
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ceiling well above the roughly 2650 cycles the tests take
   always @(posedge CORE_CLK_I)
   begin
      cyc++;
      if (cyc > 6000)
      begin
         num_errors++;
         $display("ERROR timeout expected 6000 seen %0d", cyc);
         conclude();
      end
   end
   initial
   begin
      {BUS_ADDR_I, BUS_WDATA_I, BUS_WR_I, BUS_RD_I, go} = '0;
      {BUF_UNDERFLOW_I, BUF_OVERFLOW_I, WORD_SYNC_SENT_I} = '0;
      RST_B_I = 1'b0;
      repeat (8) @(posedge CORE_CLK_I);
      RST_B_I <= 1'b1;
      t_reset();
      t_bist();
      t_fault();
      conclude();
   end
endmodule
bind txpei_top txpei_asserts i_txpei_asserts
(
   .CORE_CLK_I        (CORE_CLK_I),
   .RST_B_I           (RST_B_I),
   .BUS_ADDR_I        (BUS_ADDR_I),
   .BUS_WDATA_I       (BUS_WDATA_I),
   .BUS_WR_I          (BUS_WR_I),
   .BUS_RD_I          (BUS_RD_I),
   .BUS_RDATA_O       (BUS_RDATA_O),
   .BUF_UNDERFLOW_I   (BUF_UNDERFLOW_I),
   .BUF_OVERFLOW_I    (BUF_OVERFLOW_I),
   .WORD_SYNC_SENT_I  (WORD_SYNC_SENT_I),
   .TX_PATH_ERROR_A_O (TX_PATH_ERROR_A_O),
   .TX_PATH_ERROR_B_O (TX_PATH_ERROR_B_O),
   .TX_PATH_ERROR_C_O (TX_PATH_ERROR_C_O),
   .TX_PATH_ERROR_D_O (TX_PATH_ERROR_D_O),
   .REALIGN_ACTIVE_O  (REALIGN_ACTIVE_O),
   .IRQ_O             (IRQ_O)
);
